// file: src/touch_recal_pkg.sv
// Constants, types and register map of the group timing and recal block
package touch_recal_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_HOLD_CFG   = 8'h23;
    localparam logic [7:0] ADDR_SLIDE_CFG  = 8'h24;
    localparam logic [7:0] ADDR_AUTO_RECAL = 8'h25;
    localparam logic [7:0] ADDR_FORCE      = 8'h26;
    localparam logic [7:0] ADDR_GRP_FORCE  = 8'h46;
    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_HOLD_CFG    = 8'h47;
    localparam logic [7:0] RST_SLIDE_CFG   = 8'hD4;
    localparam logic [7:0] RST_AUTO_RECAL  = 8'hFF;
    localparam logic [7:0] RST_FORCE       = 8'h00;
    localparam int HOLD_RPT_LSB   = 4;
    localparam int MIN_PRESS_LSB  = 0;
    localparam int MAX_DUR_LSB    = 4;
    localparam int SLIDE_RPT_LSB  = 0;
    localparam int GROUP_BIT      = 7;
    localparam int NUM_CH         = 14;
    localparam int GRP_LO         = 8;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ        = 200000;
    localparam int TICK_MS        = 35;
    localparam int TICK_CYCLES    = TICK_MS * CLK_KHZ;
    localparam int RECAL_MAX_MS   = 600;
    localparam int RECAL_TICKS    = RECAL_MAX_MS / TICK_MS;
    localparam int ANALOG_TICKS   = 8;
    localparam int DIGITAL_TICKS  = RECAL_TICKS - ANALOG_TICKS;
    localparam int MAX_DUR_MS [16] = '{560, 840, 1120, 1400, 1680, 2240,
        2800, 3360, 3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200};
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;
    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_ANALOG,
        CAL_DIGITAL,
        CAL_BLOCKED
    } cal_state_t;
endpackage

// file: src/touch_group_recal_ctrl.sv
// Group timing, tap/hold classification and recalibration control
// Summary of operation
// - Hold register upper nibble sets hold repeat interval, reset 0100b.
// - Repeat codes give 35 ms steps from 35 ms to 560 ms.
// - Group touch longer than min-press time is press-and-hold; reset 280 ms.
// - Group touch no longer than min-press time is a tap.
// - Min-press code n means (n+1) times 35 ms.
// - Min-press timing ignores slides; slides are separate events.
// - Slide register upper nibble sets group max press time, reset 1101b.
// - Slide register lower nibble sets base slide repeat interval, 0100b.
// - Auto recal bit 7 enables group auto recal; register resets all ones.
// - Auto recal bits 6..0 permit auto recal of inputs 7..1.
// - Auto recal enable ignored for sensors not sampled.
// - Group auto recal off; host may still force group recal.
// - Forced recal bit starts recal, self-clears when done; resets zero.
// - Group forced register bits 6..0 cover inputs 14..8; bit 7 unused.
// - Group forced bit recals all grouped, clears after all succeed.
// - Forced recal runs analog phase, then digital base capture.
// - During recal no presses reported, base counts invalid, 600 ms max.
// - A press during recal invalidates it, except in a max-duration recal.
// - Press past max duration restarts recal when enabled; 1101 is 8906 ms.
// - Repeat enabled: hold irq at detection and every repeat interval.
module touch_group_recal_ctrl
    import touch_recal_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire reg_req_t          regReq,
    output logic [7:0]             regRdData,
    input  wire logic [NUM_CH:1]   rawTouch,
    input  wire logic [NUM_CH:1]   sensorEnable,
    input  wire logic              groupRepeatEnable,
    input  wire logic              groupMaxPressRecalEnable,
    output logic [NUM_CH:1]        reportedTouch,
    output logic [NUM_CH:1]        baseCountValid,
    output logic [NUM_CH:1]        calAnalogActive,
    output logic [NUM_CH:1]        calDigitalActive,
    output logic [NUM_CH:1]        autoRecalPermit,
    output logic                   groupTap,
    output logic                   groupPressHold,
    output logic                   groupHoldIrq,
    output logic [4:0]             slideBaseTicks
);
    // ----------------------------------------------------------------
    // Common 35 ms tick
    // ----------------------------------------------------------------
    logic [31:0] divCnt_q, divCnt_d;
    logic        tick;
    always_comb begin
        tick     = (divCnt_q == 32'(TICK_DIV - 1));
        divCnt_d = tick ? 32'h0 : divCnt_q + 32'h1;
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) divCnt_q <= 32'h0;
        else         divCnt_q <= divCnt_d;
    end

    function automatic logic [4:0] codeTicks(input logic [3:0] code);
        return {1'b0, code} + 5'h1;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]        holdCfg_q, holdCfg_d, slideCfg_q, slideCfg_d;
    logic [7:0]        autoCfg_q, autoCfg_d, force_q, force_d;
    logic [6:0]        grpForce_q, grpForce_d, grpPend_q, grpPend_d;
    logic [7:0]        rdData_q, rdData_d;
    logic [NUM_CH:1]   calOk, forceReq, calBusy;
    always_comb begin
        holdCfg_d  = holdCfg_q;
        slideCfg_d = slideCfg_q;
        autoCfg_d  = autoCfg_q;
        force_d    = {1'b0, force_q[6:0] & ~calOk[7:1]};
        grpForce_d = grpForce_q & ~calOk[NUM_CH:GRP_LO];
        grpPend_d  = grpPend_q & ~calOk[NUM_CH:GRP_LO];
        rdData_d   = rdData_q;
        // A write lands after the hardware clear, so a set wins
        if (regReq.wr) begin
            if (regReq.addr == ADDR_HOLD_CFG) begin
                holdCfg_d = regReq.data;
            end else if (regReq.addr == ADDR_SLIDE_CFG) begin
                slideCfg_d = regReq.data;
            end else if (regReq.addr == ADDR_AUTO_RECAL) begin
                autoCfg_d = regReq.data;
            end else if (regReq.addr == ADDR_FORCE) begin
                force_d   = {1'b0, regReq.data[6:0]};
                grpPend_d = {7{regReq.data[GROUP_BIT]}};
            end else if (regReq.addr == ADDR_GRP_FORCE) begin
                grpForce_d = regReq.data[6:0];
            end
        end
        if (regReq.rd) begin
            if (regReq.addr == ADDR_HOLD_CFG)        rdData_d = holdCfg_q;
            else if (regReq.addr == ADDR_SLIDE_CFG)  rdData_d = slideCfg_q;
            else if (regReq.addr == ADDR_AUTO_RECAL) rdData_d = autoCfg_q;
            else if (regReq.addr == ADDR_FORCE)
                rdData_d = {|grpPend_q, force_q[6:0]};
            else if (regReq.addr == ADDR_GRP_FORCE)
                rdData_d = {1'b0, grpForce_q};
            else rdData_d = 8'h00;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            holdCfg_q  <= RST_HOLD_CFG;
            slideCfg_q <= RST_SLIDE_CFG;
            autoCfg_q  <= RST_AUTO_RECAL;
            force_q    <= RST_FORCE;
            grpForce_q <= RST_FORCE[6:0];
            grpPend_q  <= RST_FORCE[6:0];
            rdData_q   <= 8'h00;
        end else begin
            holdCfg_q  <= holdCfg_d;
            slideCfg_q <= slideCfg_d;
            autoCfg_q  <= autoCfg_d;
            force_q    <= force_d;
            grpForce_q <= grpForce_d;
            grpPend_q  <= grpPend_d;
            rdData_q   <= rdData_d;
        end
    end
    assign regRdData      = rdData_q;
    assign forceReq       = {grpForce_q | grpPend_q, force_q[6:0]};
    assign slideBaseTicks = codeTicks(slideCfg_q[SLIDE_RPT_LSB +: 4]);
    // Auto recal itself runs in the sampler; here only the permission
    assign autoRecalPermit = sensorEnable &
        {{7{autoCfg_q[GROUP_BIT]}}, autoCfg_q[6:0]};
    assign reportedTouch = rawTouch & sensorEnable & ~calBusy;

    // ----------------------------------------------------------------
    // Group press timing
    // ----------------------------------------------------------------
    logic [8:0] holdCnt_q, holdCnt_d;
    logic [4:0] rptCnt_q, rptCnt_d;
    logic       grpTouch_q, phSeen_q, phSeen_d, mdDone_q, mdDone_d;
    logic       grpTouch, mdTrig, rptPulse;
    logic [8:0] maxTicks;
    logic [4:0] minTicks, rptTicks;
    // Slides are judged elsewhere and never touch these counters
    always_comb begin
        grpTouch  = |reportedTouch[NUM_CH:GRP_LO];
        minTicks  = codeTicks(holdCfg_q[MIN_PRESS_LSB +: 4]);
        rptTicks  = codeTicks(holdCfg_q[HOLD_RPT_LSB +: 4]);
        maxTicks  = 9'(MAX_DUR_MS[slideCfg_q[MAX_DUR_LSB +: 4]]
                       / TICK_MS);
        holdCnt_d = holdCnt_q;
        rptCnt_d  = rptCnt_q;
        phSeen_d  = phSeen_q;
        mdDone_d  = mdDone_q;
        groupPressHold = 1'b0;
        rptPulse  = 1'b0;
        mdTrig    = 1'b0;
        groupTap  = grpTouch_q && !grpTouch && !phSeen_q;
        if (!grpTouch) begin
            holdCnt_d = 9'h0;
            rptCnt_d  = 5'h0;
            phSeen_d  = 1'b0;
            mdDone_d  = 1'b0;
        end else if (tick) begin
            if (holdCnt_q != 9'h1FF) holdCnt_d = holdCnt_q + 9'h1;
            if (!phSeen_q && holdCnt_q == {4'h0, minTicks}) begin
                groupPressHold = 1'b1;
                phSeen_d = 1'b1;
            end
            if (phSeen_q) begin
                rptPulse = (rptCnt_q == rptTicks - 5'h1);
                rptCnt_d = rptPulse ? 5'h0 : rptCnt_q + 5'h1;
            end
            // Same convention as min-press: full ticks must have passed
            if (groupMaxPressRecalEnable && !mdDone_q &&
                holdCnt_q >= maxTicks) begin
                mdTrig   = 1'b1;
                mdDone_d = 1'b1;
            end
        end
        groupHoldIrq = groupPressHold ||
                       (groupRepeatEnable && rptPulse);
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            holdCnt_q  <= 9'h0;
            rptCnt_q   <= 5'h0;
            grpTouch_q <= 1'b0;
            phSeen_q   <= 1'b0;
            mdDone_q   <= 1'b0;
        end else begin
            holdCnt_q  <= holdCnt_d;
            rptCnt_q   <= rptCnt_d;
            grpTouch_q <= grpTouch;
            phSeen_q   <= phSeen_d;
            mdDone_q   <= mdDone_d;
        end
    end

    // ----------------------------------------------------------------
    // Per-sensor recalibration sequencer
    // ----------------------------------------------------------------
    for (genvar i = 1; i <= NUM_CH; i++) begin : g_ch
        cal_state_t st_q, st_d;
        logic [4:0] cnt_q, cnt_d;
        logic       keep_q, keep_d, abort, md;
        // Max-duration recal must calibrate under the held finger
        assign md    = mdTrig && (i >= GRP_LO) && rawTouch[i];
        assign abort = rawTouch[i] && !keep_q;
        assign calOk[i] = (st_q == CAL_DIGITAL) && tick && !abort &&
                          (cnt_q == 5'(DIGITAL_TICKS - 1));
        always_comb begin
            st_d   = st_q;
            cnt_d  = tick ? cnt_q + 5'h1 : cnt_q;
            keep_d = keep_q;
            case (st_q)
                CAL_IDLE: begin
                    cnt_d  = 5'h0;
                    keep_d = md;
                    if (md || forceReq[i]) st_d = CAL_ANALOG;
                end
                CAL_ANALOG: begin
                    if (abort) begin
                        st_d = CAL_BLOCKED;
                    end else if (tick &&
                                 cnt_q == 5'(ANALOG_TICKS - 1)) begin
                        st_d  = CAL_DIGITAL;
                        cnt_d = 5'h0;
                    end
                end
                CAL_DIGITAL: begin
                    if (abort)      st_d = CAL_BLOCKED;
                    else if (calOk[i]) st_d = CAL_IDLE;
                end
                default: begin
                    cnt_d = 5'h0;
                    if (!rawTouch[i]) st_d = CAL_IDLE;
                end
            endcase
        end
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                st_q   <= CAL_IDLE;
                cnt_q  <= 5'h0;
                keep_q <= 1'b0;
            end else begin
                st_q   <= st_d;
                cnt_q  <= cnt_d;
                keep_q <= keep_d;
            end
        end
        assign calAnalogActive[i]  = (st_q == CAL_ANALOG);
        assign calDigitalActive[i] = (st_q == CAL_DIGITAL);
        assign calBusy[i]          = (st_q == CAL_ANALOG) ||
                                     (st_q == CAL_DIGITAL);
        assign baseCountValid[i]   = (st_q == CAL_IDLE);
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_rst_hold;
        @(posedge sys_clk) $rose(resetn) |-> holdCfg_q == RST_HOLD_CFG;
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("hold config reset value wrong");
    property p_force_clear;
        @(posedge sys_clk) disable iff (!resetn)
        calOk[1] && !regReq.wr |=> !force_q[0];
    endproperty
    a_force_clear: assert property (p_force_clear)
        else $error("forced bit not cleared after recal");
    property p_no_report;
        @(posedge sys_clk) disable iff (!resetn)
        (calBusy & reportedTouch) == '0;
    endproperty
    a_no_report: assert property (p_no_report)
        else $error("touch reported during recal");
    property p_abort;
        @(posedge sys_clk) disable iff (!resetn)
        g_ch[13].st_q == CAL_ANALOG && rawTouch[13] && !g_ch[13].keep_q
        |=> g_ch[13].st_q == CAL_BLOCKED
        ##1 (grpForce_q[5] || grpPend_q[5]);
    endproperty
    a_abort: assert property (p_abort)
        else $error("press did not invalidate recal");
    property p_tap;
        @(posedge sys_clk) disable iff (!resetn)
        groupTap |-> $past(holdCnt_q) <= {4'h0, minTicks} && !phSeen_q;
    endproperty
    a_tap: assert property (p_tap)
        else $error("tap after press-and-hold time");
    property p_hold;
        @(posedge sys_clk) disable iff (!resetn)
        groupPressHold |-> tick && holdCnt_q == {4'h0, minTicks}
        ##1 phSeen_q;
    endproperty
    a_hold: assert property (p_hold)
        else $error("press-and-hold at wrong time");
    property p_group_pend;
        @(posedge sys_clk) disable iff (!resetn)
        grpPend_q[0] && !calOk[GRP_LO] && !regReq.wr |=> grpPend_q[0];
    endproperty
    a_group_pend: assert property (p_group_pend)
        else $error("group forced bit cleared early");
    property p_permit;
        @(posedge sys_clk) disable iff (!resetn)
        (autoRecalPermit & ~sensorEnable) == '0;
    endproperty
    a_permit: assert property (p_permit)
        else $error("auto recal permitted on unsampled sensor");
    property p_repeat;
        @(posedge sys_clk) disable iff (!resetn)
        groupHoldIrq && !groupPressHold |-> groupRepeatEnable && phSeen_q;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat irq without enabled hold");
endmodule

// file: verification/host_reg_model.sv
// Host-side model driving the register strobe port of the block
module host_reg_model
    import touch_recal_pkg::*;
(
    input  wire logic       sys_clk,
    output reg_req_t        regReq,
    input  wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    // Strobes idle low; address and data start at zero, then show the inverse between strobes
    initial regReq = '0;

    // Forced recal requests are written here too
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: v};
        @(negedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~v};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h5A};
        @(negedge sys_clk);
        regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hA5};
        v = regRdData;
    endtask
endmodule

// file: verification/tb_touch_group_recal_ctrl.sv
// Self-checking bench for the group timing and recal block
module tb_touch_group_recal_ctrl
    import touch_recal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    localparam int TD = 20;
    localparam int MIN_T = 3;
    localparam int RPT_T = 2;
    localparam int MAXD_T = 16;
    logic            sys_clk = 1'b0;
    logic            resetn = 1'b0;
    reg_req_t        regReq;
    logic [7:0]      regRdData, rdVal, d;
    logic [NUM_CH:1] rawTouch = '0;
    logic [NUM_CH:1] sensorEnable = '1;
    logic [NUM_CH:1] reportedTouch, baseCountValid, calAnalogActive;
    logic [NUM_CH:1] calDigitalActive, autoRecalPermit, en, raw;
    logic            groupRepeatEnable = 1'b0;
    logic            groupMaxPressRecalEnable = 1'b0;
    logic            groupTap, groupPressHold, groupHoldIrq, seen;
    logic [4:0]      slideBaseTicks;
    logic [7:0]      regModel [256];
    logic [7:0]      addrList [$] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h46};
    int              fails = 0;
    int              checksDone = 0;
    int              seed = 21892;
    int              i, aCnt, dCnt;

    always #2.5 sys_clk = ~sys_clk;

    touch_group_recal_ctrl #(.TICK_DIV(TD)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .regReq(regReq),
        .regRdData(regRdData), .rawTouch(rawTouch),
        .sensorEnable(sensorEnable),
        .groupRepeatEnable(groupRepeatEnable),
        .groupMaxPressRecalEnable(groupMaxPressRecalEnable),
        .reportedTouch(reportedTouch), .baseCountValid(baseCountValid),
        .calAnalogActive(calAnalogActive),
        .calDigitalActive(calDigitalActive),
        .autoRecalPermit(autoRecalPermit), .groupTap(groupTap),
        .groupPressHold(groupPressHold), .groupHoldIrq(groupHoldIrq),
        .slideBaseTicks(slideBaseTicks));

    host_reg_model host (.sys_clk(sys_clk), .regReq(regReq),
        .regRdData(regRdData));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (fails == 0 && checksDone > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Unmapped writes leave the model untouched
    task automatic regWr(input logic [7:0] a, input logic [7:0] v);
        host.wr(a, v);
        if (a inside {addrList})
            regModel[a] = (a == 8'h46) ? (v & 8'h7F) : v;
    endtask

    task automatic regChk(input logic [7:0] a);
        host.rd(a, rdVal);
        check({8'h00, rdVal}, {8'h00, regModel[a]});
    endtask

    // The model clears the request bits once every sequencer is idle again
    task automatic waitIdle(input logic [7:0] a);
        repeat (3) @(negedge sys_clk);
        for (int k = 0; k < 30 * TD && baseCountValid !== '1; k++)
            @(negedge sys_clk);
        regModel[a] = 8'h00;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        foreach (regModel[k]) regModel[k] = 8'h00;
        regModel[8'h23] = 8'h47;
        regModel[8'h24] = 8'hD4;
        regModel[8'h25] = 8'hFF;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        foreach (addrList[k]) regChk(addrList[k]);
        regWr(8'h30, 8'hA5);
        regChk(8'h30);
        for (i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            regWr(8'h24, {d[7:4], 4'(i)});
            regChk(8'h24);
            check({11'h0, slideBaseTicks}, 16'(i + 1));
        end
        regWr(8'h23, 8'($random(seed)));
        regChk(8'h23);
        for (i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            en = NUM_CH'($random(seed));
            raw = NUM_CH'($random(seed));
            regWr(8'h25, d);
            sensorEnable = en;
            rawTouch = raw;
            #1;
            check(16'(autoRecalPermit),
                16'({{7{d[7]}} & en[14:8], d[6:0] & en[7:1]}));
            check(16'(reportedTouch), 16'(raw & en));
            regChk(8'h25);
        end
        rawTouch = '0;
        sensorEnable = '1;
        // Short grouped touch is a tap, long one a hold with repeats
        regWr(8'h23, 8'h12);
        groupRepeatEnable = 1'b1;
        seen = 1'b0;
        rawTouch[10] = 1'b1;
        repeat (TD) begin
            @(negedge sys_clk);
            seen |= groupPressHold;
        end
        check({15'h0, seen}, 16'h0);
        rawTouch[10] = 1'b0;
        seen = 1'b0;
        repeat (3) begin
            #1 seen |= groupTap;
            @(negedge sys_clk);
        end
        check({15'h0, seen}, 16'h1);
        repeat (3 * TD) @(negedge sys_clk);
        rawTouch[12] = 1'b1;
        for (i = 0; i < 10 * TD && groupPressHold !== 1'b1; i++)
            @(negedge sys_clk);
        check(16'(i > MIN_T * TD && i <= (MIN_T + 1) * TD), 16'h1);
        check({15'h0, groupHoldIrq}, 16'h1);
        @(negedge sys_clk);
        for (i = 1; i < 10 * TD && groupHoldIrq !== 1'b1; i++)
            @(negedge sys_clk);
        check(16'(i), 16'(RPT_T * TD));
        rawTouch[12] = 1'b0;
        seen = 1'b0;
        repeat (3) begin
            #1 seen |= groupTap;
            @(negedge sys_clk);
        end
        check({15'h0, seen}, 16'h0);
        groupRepeatEnable = 1'b0;
        // Held group press past the max time recalibrates under the finger
        regWr(8'h24, 8'h04);
        groupMaxPressRecalEnable = 1'b1;
        rawTouch[9] = 1'b1;
        for (i = 0; i < 20 * TD && calAnalogActive[9] !== 1'b1; i++)
            @(negedge sys_clk);
        check(16'(i > MAXD_T * TD + 1 &&
            i <= (MAXD_T + 1) * TD + 1), 16'h1);
        for (i = 0; i < 30 * TD && baseCountValid[9] !== 1'b1; i++)
            @(negedge sys_clk);
        check({15'h0, baseCountValid[9]}, 16'h1);
        rawTouch[9] = 1'b0;
        groupMaxPressRecalEnable = 1'b0;
        regChk(8'h26);
        // Forced recal of one input, spoiled by a press, then retried
        regWr(8'h26, 8'h01);
        repeat (3) @(negedge sys_clk);
        rawTouch[1] = 1'b1;
        #1 check({15'h0, reportedTouch[1]}, 16'h0);
        check({15'h0, baseCountValid[1]}, 16'h0);
        repeat (30 * TD) @(negedge sys_clk);
        regChk(8'h26);
        rawTouch[1] = 1'b0;
        aCnt = 0;
        dCnt = 0;
        seen = 1'b0;
        for (i = 0; i < 30 * TD && !(baseCountValid[1] === 1'b1 &&
                aCnt > 0); i++) begin
            @(negedge sys_clk);
            aCnt += int'(calAnalogActive[1] === 1'b1);
            dCnt += int'(calDigitalActive[1] === 1'b1);
            if (calDigitalActive[1] === 1'b1 && aCnt == 0) seen = 1'b1;
        end
        check(16'(aCnt > 7 * TD && aCnt <= 8 * TD + 1), 16'h1);
        check(16'(dCnt >= 9 * TD - 1 && dCnt <= 9 * TD + 1), 16'h1);
        check({15'h0, seen}, 16'h0);
        waitIdle(8'h26);
        regChk(8'h26);
        // Group request with auto recal off; one input spoils its run
        regWr(8'h25, 8'h00);
        regWr(8'h26, 8'h80);
        repeat (3) @(negedge sys_clk);
        check({9'h0, calAnalogActive[14:8]}, 16'h007F);
        rawTouch[13] = 1'b1;
        repeat (30 * TD) @(negedge sys_clk);
        regChk(8'h26);
        rawTouch[13] = 1'b0;
        waitIdle(8'h26);
        regChk(8'h26);
        regWr(8'h46, 8'h81);
        repeat (3) @(negedge sys_clk);
        check({9'h0, calAnalogActive[14:8]}, 16'h0001);
        regChk(8'h46);
        waitIdle(8'h46);
        regChk(8'h46);
        results();
    end

    initial begin
        #50000;
        fails++;
        results();
    end
endmodule
